/* File: core/fsg_frame_sync.sv */
// frame sync sequencer and eight-pin control for an image sensor
// assumes host writes arrive as decoded strobes from the serial register port
//
// Functional notes
// - leader without pin sync streams right after the start command executes.
// - pin-started leader finishes setup, then waits for sync pin rising edge.
// - follower mode starts a frame per pin pulse or per host trigger.
// - eight pins; sync pin acts as plain pin when sync unused.
// - pins 1-7 select pwm, strobe, vsync or plain pin function.
// - four per-context pin setting sets; active context's set applies.
// - any internal signal may drive one or several pins at once.
// - every pin has a polarity invert setting.
// - in standby each pin is input, low output or high output.
// - all pins stay low during reset until configured.
// - host configures everything through register accesses.
// - internal controller applies host settings before streaming.
// - four contexts, each with frame count, chained ending or repeating.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"

module fsg_frame_sync #(
  parameter int NUM_PINS = `FSG_NUM_PINS,
  parameter int NUM_CTX = `FSG_NUM_CTX,
  parameter int FRAME_CYC = 64,
  parameter int PWM_W = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // host register side
  input wire fsg_pkg::fsg_mode_e i_mode,
  input wire logic i_sync_en,
  input wire logic i_start_cmd,
  input wire logic i_stop_cmd,
  input wire logic i_trig_cmd,
  input wire logic i_ctx_start,
  input wire logic i_cfg_wr,
  input wire logic [1:0] i_cfg_ctx,
  input wire fsg_pkg::fsg_pin_cfg_s [NUM_PINS-1:0] i_cfg_data,
  input wire fsg_pkg::fsg_ctx_cfg_s [NUM_CTX-1:0] i_ctx_cfg,
  input wire logic [NUM_PINS*2-1:0] i_standby_dir,
  input wire logic [PWM_W-1:0] i_pwm_duty,
  input wire logic [PWM_W-1:0] i_strobe_len,
  // pins
  input wire logic [NUM_PINS-1:0] i_pin_in,
  output logic [NUM_PINS-1:0] o_pin_out,
  output logic [NUM_PINS-1:0] o_pin_oe,
  // status
  output logic o_streaming,
  output logic o_frame_start,
  output logic [1:0] o_active_ctx,
  output logic [NUM_PINS-1:0] o_pin_level
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  initial begin
    if (NUM_PINS != `FSG_NUM_PINS || NUM_CTX != `FSG_NUM_CTX || FRAME_CYC < 4 ||
        FRAME_CYC > 65535 || PWM_W < 2) begin
      $error("fsg_frame_sync: unsupported parameters");
    end
  end

  // ****************************************************************
  // declarations
  // ****************************************************************
  fsg_pkg::fsg_state_e state_q, state_d;
  fsg_pkg::fsg_pin_cfg_s [NUM_PINS-1:0] pin_cfg;
  logic [NUM_PINS-1:0] meta_q, sync_q;
  logic [3:0] lat_q;
  logic [15:0] fcnt_q;
  logic [7:0] frames_left_q;
  logic [1:0] ctx_q;
  logic [PWM_W-1:0] pwm_cnt_q;
  logic [PWM_W-1:0] strobe_cnt_q;
  logic pend_q;
  logic strobe_q;
  logic vsync_q;
  logic [NUM_PINS-1:0] pin_out_q, pin_oe_q;
  logic streaming_q, frame_start_q;
  logic sync_lvl, sync_rise;

  // ****************************************************************
  // sync pin edge detect
  // ****************************************************************
  fsg_sync_edge u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pin(i_pin_in[`FSG_SYNC_PIN]),
    .i_invert(pin_cfg[`FSG_SYNC_PIN].invert),
    .o_level(sync_lvl),
    .o_rise(sync_rise)
  );

  // ****************************************************************
  // context pin settings
  // ****************************************************************
  fsg_cfg_mem #(
    .NUM_CTX(NUM_CTX),
    .NUM_PINS(NUM_PINS)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_en(i_cfg_wr),
    .i_wr_ctx(i_cfg_ctx),
    .i_wr_data(i_cfg_data),
    .i_rd_ctx(ctx_q),
    .o_rd_data(pin_cfg)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic follow = (i_mode == fsg_pkg::FSG_FOLLOW);
  wire logic lead_pin = (i_mode == fsg_pkg::FSG_LEAD_PIN);
  wire logic pin_trig = i_sync_en & sync_rise;
  wire logic trig = follow & (pin_trig | i_trig_cmd);
  wire logic frame_end = (fcnt_q == 16'(FRAME_CYC - 1));
  wire logic lat_done = (lat_q == `FSG_MCU_LAT);
  wire logic in_frame = (state_q == fsg_pkg::FSG_ST_FRAME);
  wire logic ctx_last = (frames_left_q <= 8'h01);
  wire logic [2:0] nxt_ctx = i_ctx_cfg[ctx_q].next_ctx;
  wire logic seq_end = frame_end & ctx_last & (nxt_ctx == `FSG_CTX_NONE);
  wire logic standby = (state_q == fsg_pkg::FSG_ST_STANDBY);
  wire logic pwm_sig = (pwm_cnt_q < i_pwm_duty);

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      fsg_pkg::FSG_ST_STANDBY: begin
        if (i_start_cmd) begin
          state_d = fsg_pkg::FSG_ST_APPLY;
        end
      end
      fsg_pkg::FSG_ST_APPLY: begin
        if (lat_done) begin
          if (follow || (lead_pin && i_sync_en)) begin
            state_d = fsg_pkg::FSG_ST_ARMED;
          end else begin
            state_d = fsg_pkg::FSG_ST_FRAME;
          end
        end
      end
      fsg_pkg::FSG_ST_ARMED: begin
        if (follow ? trig : sync_rise) begin
          state_d = fsg_pkg::FSG_ST_FRAME;
        end
      end
      fsg_pkg::FSG_ST_STREAM: begin
        if (trig) begin
          state_d = fsg_pkg::FSG_ST_FRAME;
        end
      end
      fsg_pkg::FSG_ST_FRAME: begin
        if (seq_end) begin
          state_d = fsg_pkg::FSG_ST_STANDBY;
        end else if (frame_end && follow && !pend_q && !trig) begin
          state_d = fsg_pkg::FSG_ST_STREAM;
        end
      end
      default: begin
        state_d = fsg_pkg::FSG_ST_STANDBY;
      end
    endcase
    if (i_stop_cmd) begin
      state_d = fsg_pkg::FSG_ST_STANDBY;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= fsg_pkg::FSG_ST_STANDBY;
      lat_q <= '0;
      fcnt_q <= '0;
      pend_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lat_q <= (state_q == fsg_pkg::FSG_ST_APPLY) ? lat_q + 4'h1 : '0;
      fcnt_q <= (in_frame && !frame_end) ? fcnt_q + 16'h1 : '0;
      // one trigger during a frame is queued for the next frame
      pend_q <= in_frame & (trig | (pend_q & ~frame_end));
    end
  end

  // ****************************************************************
  // context chaining
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      ctx_q <= '0;
      frames_left_q <= '0;
    end else if (standby && i_start_cmd) begin
      ctx_q <= {1'b0, i_ctx_start};
      frames_left_q <= i_ctx_cfg[i_ctx_start].frames;
    end else if (in_frame && frame_end) begin
      if (ctx_last && nxt_ctx != `FSG_CTX_NONE) begin
        ctx_q <= nxt_ctx[1:0];
        frames_left_q <= i_ctx_cfg[nxt_ctx[1:0]].frames;
      end else if (!ctx_last) begin
        frames_left_q <= frames_left_q - 8'h01;
      end
    end
  end

  // ****************************************************************
  // internal signal sources
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pwm_cnt_q <= '0;
      strobe_cnt_q <= '0;
      strobe_q <= 1'b0;
      vsync_q <= 1'b0;
      frame_start_q <= 1'b0;
      streaming_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 1'b1;
      frame_start_q <= in_frame & (fcnt_q == 16'h0);
      vsync_q <= in_frame & (fcnt_q < 16'(FRAME_CYC / 4));
      if (in_frame && fcnt_q == 16'h0) begin
        strobe_cnt_q <= i_strobe_len;
        strobe_q <= (i_strobe_len != '0);
      end else if (strobe_cnt_q > 1) begin
        strobe_cnt_q <= strobe_cnt_q - 1'b1;
      end else begin
        strobe_cnt_q <= '0;
        strobe_q <= 1'b0;
      end
      streaming_q <= ~standby & (state_q != fsg_pkg::FSG_ST_APPLY);
    end
  end

  // ****************************************************************
  // pin output mapping
  // ****************************************************************
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    logic fn_val, drv_val, drv_oe;
    wire logic [1:0] sb = i_standby_dir[2*p +: 2];
    wire logic sync_use = (p == `FSG_SYNC_PIN) && i_sync_en && (follow || lead_pin);
    always_comb begin
      case (pin_cfg[p].func)
        `FSG_FN_PWM: fn_val = (p != `FSG_SYNC_PIN) & pwm_sig;
        `FSG_FN_STROBE: fn_val = (p != `FSG_SYNC_PIN) & strobe_q;
        `FSG_FN_VSYNC: fn_val = (p != `FSG_SYNC_PIN) & vsync_q;
        default: fn_val = pin_cfg[p].out_val;
      endcase
      if (standby) begin
        drv_oe = (sb == `FSG_SB_LOW) || (sb == `FSG_SB_HIGH);
        drv_val = (sb == `FSG_SB_HIGH);
      end else begin
        drv_oe = ~sync_use;
        drv_val = fn_val ^ pin_cfg[p].invert;
      end
    end
    always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
        pin_out_q[p] <= 1'b0;
        pin_oe_q[p] <= 1'b1;
        meta_q[p] <= 1'b0;
        sync_q[p] <= 1'b0;
      end else begin
        pin_out_q[p] <= drv_oe & drv_val;
        pin_oe_q[p] <= drv_oe;
        meta_q[p] <= i_pin_in[p];
        sync_q[p] <= meta_q[p];
      end
    end
  end

  assign o_pin_out = pin_out_q;
  assign o_pin_oe = pin_oe_q;
  assign o_pin_level = sync_q;
  assign o_streaming = streaming_q;
  assign o_frame_start = frame_start_q;
  assign o_active_ctx = ctx_q;

endmodule // fsg_frame_sync
`default_nettype wire

/* File: core/fsg_defines.svh */
// constants for the frame sync and pin control block
// assumes inclusion by bare name from the core folder
`ifndef FSG_DEFINES_SVH
`define FSG_DEFINES_SVH

`define FSG_NUM_PINS 8
`define FSG_NUM_CTX 4
`define FSG_SYNC_PIN 0
`define FSG_FN_W 2
`define FSG_FN_GPIO 2'h0
`define FSG_FN_PWM 2'h1
`define FSG_FN_STROBE 2'h2
`define FSG_FN_VSYNC 2'h3
`define FSG_SB_IN 2'h0
`define FSG_SB_LOW 2'h1
`define FSG_SB_HIGH 2'h2
`define FSG_CTX_NONE 3'h4
`define FSG_MCU_LAT 4'h3

`endif

/* File: core/fsg_pkg.sv */
// shared types for the frame sync and pin control block
// assumes fsg_defines.svh sits in the same folder
`include "fsg_defines.svh"

package fsg_pkg;

  // sync modes
  typedef enum logic [1:0] {
    FSG_LEAD_CMD = 2'h0,
    FSG_LEAD_PIN = 2'h1,
    FSG_FOLLOW = 2'h3
  } fsg_mode_e;

  // sequencer states, gray codes in declaration order
  typedef enum logic [2:0] {
    FSG_ST_STANDBY = 3'h0,
    FSG_ST_APPLY = 3'h1,
    FSG_ST_ARMED = 3'h3,
    FSG_ST_STREAM = 3'h2,
    FSG_ST_FRAME = 3'h6
  } fsg_state_e;

  // one pin's setting within one context
  typedef struct packed {
    logic [1:0] func;
    logic invert;
    logic out_val;
  } fsg_pin_cfg_s;

  // one context's chaining setting
  typedef struct packed {
    logic [7:0] frames;
    logic [2:0] next_ctx;
  } fsg_ctx_cfg_s;

endpackage

/* File: core/fsg_cfg_mem.sv */
// per-context pin settings store, registered read
// assumes writes come from the register-side logic on the same clock
`timescale 1ns/1ps
`default_nettype none
`include "fsg_defines.svh"

module fsg_cfg_mem #(
  parameter int NUM_CTX = `FSG_NUM_CTX,
  parameter int NUM_PINS = `FSG_NUM_PINS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_wr_en,
  input wire logic [$clog2(NUM_CTX)-1:0] i_wr_ctx,
  input wire fsg_pkg::fsg_pin_cfg_s [NUM_PINS-1:0] i_wr_data,
  input wire logic [$clog2(NUM_CTX)-1:0] i_rd_ctx,
  output fsg_pkg::fsg_pin_cfg_s [NUM_PINS-1:0] o_rd_data
);

  fsg_pkg::fsg_pin_cfg_s [NUM_PINS-1:0] mem_q [NUM_CTX];

  always_ff @(posedge i_sys_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_ctx] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem_q[i_rd_ctx];
    end
  end

endmodule // fsg_cfg_mem
`default_nettype wire

/* File: core/fsg_sync_edge.sv */
// two-flop synchroniser with polarity-aware edge detect
// assumes the input pin is asynchronous to i_sys_clk
`timescale 1ns/1ps
`default_nettype none

module fsg_sync_edge (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic i_invert,
  output logic o_level,
  output logic o_rise
);

  logic meta_q;
  logic sync_q;
  logic prev_q;
  wire logic act_level = sync_q ^ i_invert;

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      // idle high so no false edge after reset
      prev_q <= 1'b1;
    end else begin
      meta_q <= i_pin;
      sync_q <= meta_q;
      prev_q <= act_level;
    end
  end

  assign o_level = act_level;
  assign o_rise = act_level & ~prev_q;

endmodule // fsg_sync_edge
`default_nettype wire

/* File: verification/fsg_frame_sync_checker.sv */
// port-level checks for the frame sync and pin control block
// assumes a bind onto fsg_frame_sync, one clock domain
`timescale 1ns/1ps
`default_nettype none
module fsg_frame_sync_checker #(
  parameter int NUM_PINS = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire fsg_pkg::fsg_mode_e i_mode,
  input wire logic i_sync_en,
  input wire logic i_start_cmd,
  input wire logic i_stop_cmd,
  input wire logic [NUM_PINS*2-1:0] i_standby_dir,
  input wire logic [NUM_PINS-1:0] i_pin_in,
  input wire logic [NUM_PINS-1:0] o_pin_out,
  input wire logic [NUM_PINS-1:0] o_pin_oe,
  input wire logic o_streaming,
  input wire logic o_frame_start
);
  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  AST_RST_LOW: assert property (disable iff (1'b0)
    i_rst |=> o_pin_out == '0 && !o_streaming) else $error("pins not low in reset");
  AST_CMD_START: assert property (
    i_mode == fsg_pkg::FSG_LEAD_CMD && i_start_cmd && !o_streaming |-> ##[1:16] o_frame_start)
    else $error("no frame after start command");
  AST_PIN_HOLD: assert property (
    i_mode == fsg_pkg::FSG_LEAD_PIN && i_sync_en && i_start_cmd && !o_streaming && !i_pin_in[0]
    |=> !o_frame_start [*8]) else $error("frame before sync edge");
  AST_SYNC_LAT: assert property (
    i_mode == fsg_pkg::FSG_FOLLOW && $rose(i_pin_in[0]) |-> !o_frame_start [*3])
    else $error("pin edge acted on unsynchronised");
  AST_PULSE: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start longer than one cycle");
  AST_IN_STREAM: assert property (o_frame_start |-> o_streaming)
    else $error("frame start outside streaming");
  AST_SYNC_OE: assert property (
    o_streaming && $past(o_streaming) && i_sync_en && i_mode != fsg_pkg::FSG_LEAD_CMD
    |-> !o_pin_oe[0]) else $error("sync pin driven");
  AST_STOP: assert property (i_stop_cmd && !i_start_cmd |=> ##1 !o_streaming)
    else $error("stop ignored");
  AST_STBY_PIN: assert property (
    (!o_streaming && !i_start_cmd && $stable(i_standby_dir)) [*8]
    |-> o_pin_oe[1] == (i_standby_dir[3:2] inside {2'h1, 2'h2})
    && o_pin_out[1] == (i_standby_dir[3:2] == 2'h2)) else $error("standby pin wrong");
endmodule // fsg_frame_sync_checker
bind fsg_frame_sync fsg_frame_sync_checker #(.NUM_PINS(NUM_PINS)) u_chk (.i_sys_clk, .i_rst,
  .i_mode, .i_sync_en, .i_start_cmd, .i_stop_cmd, .i_standby_dir, .i_pin_in, .o_pin_out,
  .o_pin_oe, .o_streaming, .o_frame_start);
`default_nettype wire

/* File: verification/fsg_host_model.sv */
// host side pin driver: sync pulses on pin 0, held levels elsewhere
// assumes requests arrive as one-cycle strobes on i_sys_clk
`timescale 1ns/1ps
`default_nettype none
module fsg_host_model (
  input wire logic i_sys_clk,
  input wire logic i_fire,
  input wire logic [6:0] i_aux,
  output logic [7:0] o_pins
);
  logic [2:0] hold_q = 3'h0;
  // four-cycle sync pulse per request
  always_ff @(posedge i_sys_clk) begin
    if (i_fire) begin
      hold_q <= 3'h4;
    end else if (hold_q != 3'h0) begin
      hold_q <= hold_q - 3'h1;
    end
  end
  assign o_pins = {i_aux, hold_q != 3'h0};
endmodule // fsg_host_model
`default_nettype wire

/* File: verification/test_fsg_frame_sync.sv */
// self-checking bench for the frame sync and pin control block
// assumes the design, checker and host model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_fsg_frame_sync;
  localparam int FCYC = 32;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  fsg_pkg::fsg_mode_e i_mode = fsg_pkg::FSG_LEAD_CMD;
  logic i_sync_en = 1'b0, i_start_cmd = 1'b0, i_stop_cmd = 1'b0, i_trig_cmd = 1'b0;
  logic i_ctx_start = 1'b0, i_cfg_wr = 1'b0, fire = 1'b0;
  logic [1:0] i_cfg_ctx = 2'h0;
  fsg_pkg::fsg_pin_cfg_s [7:0] i_cfg_data = '0;
  fsg_pkg::fsg_ctx_cfg_s [3:0] i_ctx_cfg = {4{11'h00C}};
  logic [15:0] i_standby_dir = 16'h5555;
  logic [7:0] i_pin_in, o_pin_out, o_pin_oe;
  logic o_streaming, o_frame_start;
  logic [1:0] o_active_ctx;
  int err_count = 0, n_checks = 0, n = 0, fc = 0, cyc_cnt = 0;
  fsg_frame_sync #(.FRAME_CYC(FCYC)) dut (.i_sys_clk, .i_rst, .i_mode, .i_sync_en,
    .i_start_cmd, .i_stop_cmd, .i_trig_cmd, .i_ctx_start, .i_cfg_wr, .i_cfg_ctx,
    .i_cfg_data, .i_ctx_cfg, .i_standby_dir, .i_pwm_duty(8'h40), .i_strobe_len(8'h06),
    .i_pin_in, .o_pin_out, .o_pin_oe, .o_streaming, .o_frame_start, .o_active_ctx,
    .o_pin_level());
  fsg_host_model host (.i_sys_clk, .i_fire(fire), .i_aux(7'h00), .o_pins(i_pin_in));
  // ****************
  // helpers
  // ****************
  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic cmd(input int k); // one-cycle host strobe
    @(posedge i_sys_clk);
    case (k)
      0: i_start_cmd <= 1'b1;
      1: i_stop_cmd <= 1'b1;
      2: i_trig_cmd <= 1'b1;
      3: i_cfg_wr <= 1'b1;
      default: fire <= 1'b1;
    endcase
    @(posedge i_sys_clk);
    {i_start_cmd, i_stop_cmd, i_trig_cmd, i_cfg_wr, fire} <= 5'h0;
  endtask
  task automatic wait_frame; // bounded wait for a frame start
    n = 0;
    #1;
    while (o_frame_start !== 1'b1 && n < 64) begin
      cyc(1);
      n++;
    end
    chk({7'h0, n < 64}, 8'h01);
  endtask
  task automatic wcfg(input logic [1:0] c, input logic v);
    i_cfg_ctx <= c;
    i_cfg_data <= {4'h0, 4'h0, 4'h4, 4'h8, 4'hE, 4'hC, 3'h0, v, 4'h0};
    cmd(3);
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    cyc(16);
    i_rst <= 1'b0;
    cyc(1);
    chk(o_pin_out, 8'h00);
    chk({7'h0, o_streaming}, 8'h00);
    wcfg(2'h0, 1'b1);
    wcfg(2'h1, 1'b0);
    cmd(0);
    wait_frame();
    cyc(3);
    chk({5'h0, o_pin_out[3:1]}, 8'h03);
    chk({4'h0, o_pin_out[4:1]}, 8'h0B);
    chk({5'h0, o_pin_oe[3:1]}, 8'h07);
    cyc(12);
    chk({5'h0, o_pin_out[4:2]}, 8'h02);
    cyc(2 * FCYC);
    chk({7'h0, o_streaming}, 8'h00);
    $display("test leader_cmd done");
    i_mode <= fsg_pkg::FSG_LEAD_PIN;
    i_sync_en <= 1'b1;
    cmd(0);
    cyc(10);
    chk({6'h0, o_streaming, o_pin_oe[0]}, 8'h02);
    cmd(4);
    wait_frame();
    cmd(1);
    cyc(4);
    $display("test leader_pin done");
    i_mode <= fsg_pkg::FSG_FOLLOW;
    i_ctx_start <= 1'b1;
    i_ctx_cfg[1] <= {8'hFF, 3'h4};
    cmd(0);
    cyc(10);
    chk({4'h0, o_active_ctx, o_pin_out[1], o_frame_start}, 8'h04);
    cmd(2);
    wait_frame();
    cyc(FCYC + 4);
    cmd(4);
    fc = 0;
    repeat (3 * FCYC) begin
      cyc(1);
      fc += int'(o_frame_start);
    end
    chk(8'(fc), 8'h01);
    cmd(1);
    cyc(4);
    $display("test follower done");
    i_sync_en <= 1'b0;
    i_standby_dir <= 16'h000A;
    cyc(12);
    chk(o_pin_oe, 8'h03);
    chk(o_pin_out, 8'h03);
    $display("test standby done");
    finish_test();
  end
endmodule // test_fsg_frame_sync
`default_nettype wire
